// File: rtl/bbs_pkg.sv
// Purpose: Constants for the battery backed byte memory host controller
// Assumes: 50 MHz clock, memory strobes driven straight from flip-flops
// Notes: Cycle counts derive from printed times; least times round up
// How it works
// - Host allows at least 100 ns for every read or write cycle.
// - Host holds the controlling write strobe low at least 80 ns.
// - Address valid at strobe fall and 80 ns before terminating rise.
// - Host holds address 10 ns after the rising strobe ending a write.
// - Write data set up 50 ns before store rise, held 5 ns after.
// - Host has select or store strobe high before supply starts falling.
// - Host keeps strobes high 1 ms after supply recovers before accessing.
// - Host keeps chip select high while supply rises through trip window.
package bbs_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 20;
	localparam int CYCLE_MIN_NS = 100;
	localparam int STROBE_MIN_NS = 80;
	localparam int ADDR_HOLD_NS = 10;
	localparam int DATA_HOLD_NS = 5;
	localparam int READ_ACCESS_NS = 100;
	localparam int RELEASE_NS = 50;
	localparam int RECOVERY_MS = 1;
	localparam int NS_PER_MS = 1000000;
	localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_CYC = RECOVERY_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	typedef enum logic [2:0] {
		BBS_IDLE = 3'b000,
		BBS_RD = 3'b001,
		BBS_WR = 3'b010,
		BBS_HOLD = 3'b011,
		BBS_TURN = 3'b100
	} bbs_state_t;
endpackage : bbs_pkg

// File: rtl/bbs_recovery.sv
// Purpose: Power-up recovery timer gating memory accesses
// Assumes: supply_good_i is synchronous to clk_i
// Notes: Any loss of supply restarts the full wait
`timescale 1ns/10ps
module bbs_recovery #(
	parameter int RECOVERY_CYCLES = bbs_pkg::RECOVERY_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Supply
	input wire logic supply_good_i,
	output logic ready_o
);
	localparam int CW = $clog2(RECOVERY_CYCLES + 1);
	initial begin
		if (RECOVERY_CYCLES < 1) $error("RECOVERY_CYCLES must be at least one");
	end
	logic [CW-1:0] cnt_q, cnt_d;
	logic ready_q, ready_d;
	always_comb begin
		cnt_d = cnt_q;
		ready_d = ready_q;
		if (!supply_good_i) begin
			cnt_d = '0;
			ready_d = 1'b0;
		end else if (!ready_q) begin
			if (cnt_q == CW'(RECOVERY_CYCLES - 1)) begin
				ready_d = 1'b1;
			end else begin
				cnt_d = cnt_q + CW'(1);
			end
		end
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ready_q <= ready_d;
		end
	end
	assign ready_o = ready_q;
endmodule : bbs_recovery

// File: rtl/bbs_host.sv
// Purpose: Host side controller driving a battery backed byte-wide static memory
// Assumes: Memory pins are timed by this clock; supply_good_i synchronous
// Notes: One request at a time; writes are strobe controlled with output enable high
`timescale 1ns/10ps
module bbs_host #(
	parameter int RECOVERY_CYCLES = bbs_pkg::RECOVERY_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Supply monitor
	input wire logic supply_good_i,
	// User request
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [bbs_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [bbs_pkg::DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [bbs_pkg::DATA_W-1:0] rsp_rdata_o,
	// Memory pins
	output logic [bbs_pkg::ADDR_W-1:0] byte_select_lines_o,
	output logic chip_on_n_o,
	output logic output_on_n_o,
	output logic store_strobe_n_o,
	input wire logic [bbs_pkg::DATA_W-1:0] byte_lanes_i,
	output logic [bbs_pkg::DATA_W-1:0] byte_lanes_o,
	output logic byte_lanes_oe_o
);
	// Refuse settings that would break the minimum cycle or overflow the counter
	initial begin
		if (bbs_pkg::STROBE_CYC + bbs_pkg::HOLD_CYC <
				bbs_pkg::CYCLE_MIN_NS / bbs_pkg::CLK_PERIOD_NS) begin
			$error("Write cycle below minimum");
		end
		if (RECOVERY_CYCLES < 1) begin
			$error("RECOVERY_CYCLES must be at least one");
		end
		if (bbs_pkg::READ_CYC >= (1 << bbs_pkg::CNT_W)) begin
			$error("Phase counter too narrow");
		end
	end
	// Last cycle of a phase of n cycles
	function automatic logic cnt_done(input logic [bbs_pkg::CNT_W-1:0] c, input int n);
		return c == bbs_pkg::CNT_W'(n - 1);
	endfunction : cnt_done
	logic ready;
	bbs_recovery #(
		.RECOVERY_CYCLES(RECOVERY_CYCLES)
	) u_recovery (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.supply_good_i(supply_good_i),
		.ready_o(ready)
	);
	bbs_pkg::bbs_state_t st_q, st_d;
	logic [bbs_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [bbs_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [bbs_pkg::DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
	logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, doe_q, doe_d;
	logic rdy_q, rdy_d, rv_q, rv_d;
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		wd_d = wd_q;
		rd_d = rd_q;
		ce_n_d = ce_n_q;
		oe_n_d = oe_n_q;
		we_n_d = we_n_q;
		doe_d = doe_q;
		rdy_d = 1'b0;
		rv_d = 1'b0;
		unique case (st_q)
			bbs_pkg::BBS_IDLE: begin
				// Strobes stay high until supply has been good long enough
				ce_n_d = 1'b1;
				we_n_d = 1'b1;
				oe_n_d = 1'b1;
				rdy_d = ready;
				if (rdy_q && req_valid_i && ready) begin
					rdy_d = 1'b0;
					addr_d = req_addr_i;
					cnt_d = '0;
					ce_n_d = 1'b0;
					if (req_write_i) begin
						wd_d = req_wdata_i;
						we_n_d = 1'b0;
						doe_d = 1'b1;
						st_d = bbs_pkg::BBS_WR;
					end else begin
						oe_n_d = 1'b0;
						st_d = bbs_pkg::BBS_RD;
					end
				end
			end
			bbs_pkg::BBS_RD: begin
				cnt_d = cnt_q + bbs_pkg::CNT_W'(1);
				if (cnt_done(cnt_q, bbs_pkg::READ_CYC)) begin
					rd_d = byte_lanes_i;
					rv_d = 1'b1;
					ce_n_d = 1'b1;
					oe_n_d = 1'b1;
					cnt_d = '0;
					st_d = bbs_pkg::BBS_TURN;
				end
			end
			bbs_pkg::BBS_WR: begin
				cnt_d = cnt_q + bbs_pkg::CNT_W'(1);
				if (cnt_done(cnt_q, bbs_pkg::STROBE_CYC)) begin
					// Rising both together ends the write; data still driven
					we_n_d = 1'b1;
					ce_n_d = 1'b1;
					cnt_d = '0;
					st_d = bbs_pkg::BBS_HOLD;
				end
			end
			bbs_pkg::BBS_HOLD: begin
				cnt_d = cnt_q + bbs_pkg::CNT_W'(1);
				if (cnt_done(cnt_q, bbs_pkg::HOLD_CYC)) begin
					doe_d = 1'b0;
					cnt_d = '0;
					st_d = bbs_pkg::BBS_IDLE;
					rv_d = 1'b1;
					rdy_d = ready;
				end
			end
			bbs_pkg::BBS_TURN: begin
				// Memory may still drive after a read; wait before next drive
				cnt_d = cnt_q + bbs_pkg::CNT_W'(1);
				if (cnt_done(cnt_q, bbs_pkg::TURN_CYC)) begin
					cnt_d = '0;
					st_d = bbs_pkg::BBS_IDLE;
					rdy_d = ready;
				end
			end
			default: begin
				st_d = bbs_pkg::BBS_IDLE;
			end
		endcase
		if (!supply_good_i) begin
			// Abort: strobes high, the memory ignores us anyway
			ce_n_d = 1'b1;
			we_n_d = 1'b1;
			oe_n_d = 1'b1;
			doe_d = 1'b0;
			rdy_d = 1'b0;
			rv_d = 1'b0;
			cnt_d = '0;
			st_d = bbs_pkg::BBS_IDLE;
		end
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= bbs_pkg::BBS_IDLE;
			cnt_q <= '0;
			addr_q <= '0;
			wd_q <= '0;
			rd_q <= '0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			doe_q <= 1'b0;
			rdy_q <= 1'b0;
			rv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			ce_n_q <= ce_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			doe_q <= doe_d;
			rdy_q <= rdy_d;
			rv_q <= rv_d;
		end
	end
	assign req_ready_o = rdy_q;
	assign rsp_valid_o = rv_q;
	assign rsp_rdata_o = rd_q;
	assign byte_select_lines_o = addr_q;
	assign chip_on_n_o = ce_n_q;
	assign output_on_n_o = oe_n_q;
	assign store_strobe_n_o = we_n_q;
	assign byte_lanes_o = wd_q;
	assign byte_lanes_oe_o = doe_q;
endmodule : bbs_host

// File: testbench/bbs_host_asserts.sv
// Purpose: Pin checks for bbs_host
// Assumes: One clock domain
// Notes: Paused while supply is low, except a_supply_off which is paused only in reset
`timescale 1ns/10ps
module bbs_host_asserts #(parameter int RECOVERY_CYCLES = 8) (
	// Watched ports
	input logic clk_i, resetn_i, supply_good_i, req_ready_o, rsp_valid_o, chip_on_n_o,
	input logic output_on_n_o, store_strobe_n_o, byte_lanes_oe_o,
	input logic [12:0] byte_select_lines_o,
	input logic [7:0] byte_lanes_o
);
	int n_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i || !supply_good_i);
	always_ff @(posedge clk_i or negedge resetn_i)
		if (!resetn_i) n_q <= 0;
		else n_q <= supply_good_i ? n_q + 1 : 0;
	a_wr_width: assert property ($fell(store_strobe_n_o) |-> !store_strobe_n_o [*4])
		else $error("strobe");
	a_rd_width: assert property ($fell(output_on_n_o) |-> !output_on_n_o [*5])
		else $error("read");
	a_wr_addr: assert property (!store_strobe_n_o |=> $stable(byte_select_lines_o))
		else $error("addr");
	a_wr_data: assert property (
		!store_strobe_n_o |=> byte_lanes_oe_o && $stable(byte_lanes_o))
		else $error("data");
	a_wr_select: assert property (!store_strobe_n_o |-> !chip_on_n_o && output_on_n_o)
		else $error("select");
	a_turn_gap: assert property ($rose(output_on_n_o) |-> !byte_lanes_oe_o [*3])
		else $error("gap");
	a_recovery: assert property (req_ready_o |-> n_q >= RECOVERY_CYCLES)
		else $error("ready");
	a_supply_off: assert property (
		disable iff (!resetn_i) !supply_good_i |=> chip_on_n_o && store_strobe_n_o)
		else $error("supply");
	c_read: cover property ($rose(output_on_n_o));
	c_write: cover property ($rose(store_strobe_n_o));
	c_ready: cover property ($rose(req_ready_o));
endmodule : bbs_host_asserts

// File: testbench/bbs_mem_model.sv
// Purpose: Byte memory behind the host pins
// Assumes: Pins sampled on the host clock
// Notes: Released lanes show the inverse of the last level
`timescale 1ns/10ps
module bbs_mem_model #(parameter int LAT = 4) (
	// Host side pins
	input logic clk_i, good_i, sel_n_i, oe_n_i, we_n_i, dq_oe_i,
	input logic [12:0] addr_i,
	input logic [7:0] dq_i,
	output logic [7:0] lanes_o
);
	logic [7:0] mem_q [8192];
	logic [7:0] last_q = 8'h00;
	logic wr_q = 1'h0;
	logic rd;
	int age_q = 0;
	assign rd = !sel_n_i && !oe_n_i && we_n_i && good_i;
	assign lanes_o = dq_oe_i ? dq_i : (rd && age_q >= LAT) ? mem_q[addr_i] : ~last_q;
	always @(posedge clk_i) begin
		age_q <= rd ? age_q + 1 : 0;
		last_q <= lanes_o;
		wr_q <= !sel_n_i && !we_n_i;
		if (wr_q && (sel_n_i || we_n_i) && good_i) mem_q[addr_i] <= lanes_o;
	end
endmodule : bbs_mem_model

// File: testbench/tb_top.sv
// Purpose: Bench for bbs_host with a memory model
// Assumes: Recovery shortened to 8 cycles
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	typedef struct {logic w; logic [12:0] a; logic [7:0] d;} bbs_row_t;
	logic clk_i = 1'h0, resetn_i = 1'h0, supply_good_i = 1'h1, req_valid_i = 1'h0;
	logic req_write_i = 1'h0;
	logic [12:0] req_addr_i = 13'h0000;
	logic [7:0] req_wdata_i = 8'h00;
	logic req_ready_o, rsp_valid_o, chip_on_n_o, output_on_n_o, store_strobe_n_o, byte_lanes_oe_o;
	logic [7:0] rsp_rdata_o, byte_lanes_o, byte_lanes_i;
	logic [12:0] byte_select_lines_o;
	int miscompares = 0, total_checks = 0;
	bbs_row_t rows [6] = '{'{1'h1, 13'h0000, 8'hA5}, '{1'h1, 13'h1FFF, 8'h5A},
		'{1'h0, 13'h0000, 8'hA5}, '{1'h0, 13'h1FFF, 8'h5A}, '{1'h1, 13'h0AAA, 8'h3C},
		'{1'h0, 13'h0AAA, 8'h3C}};
	bbs_host #(.RECOVERY_CYCLES(8)) bbs_host_inst (.*);
	bbs_mem_model bbs_mem_model_inst (.clk_i, .good_i(supply_good_i), .sel_n_i(chip_on_n_o),
		.oe_n_i(output_on_n_o), .we_n_i(store_strobe_n_o), .dq_oe_i(byte_lanes_oe_o),
		.addr_i(byte_select_lines_o), .dq_i(byte_lanes_o), .lanes_o(byte_lanes_i));
	initial forever #10 clk_i = ~clk_i;
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : step
	// Bounded so a stuck handshake ends the run
	task automatic await(input bit rsp);
		int n;
		for (n = 0; n < 40 && (rsp ? rsp_valid_o : req_ready_o) !== 1'h1; n++) step(1);
		if (n == 40) begin
			miscompares++;
			results();
		end
	endtask : await
	task automatic ask(input bbs_row_t r);
		await(0);
		{req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'h1, r.w, r.a, r.d};
		step(1);
		req_valid_i = 1'h0;
	endtask : ask
	task automatic xfer(input bbs_row_t r);
		ask(r);
		await(1);
		if (!r.w) `CHK("rdata", r.d, rsp_rdata_o)
	endtask : xfer
	initial begin
		step(6);
		`CHK("idle sel", 1'h1, chip_on_n_o)
		resetn_i = 1'h1;
		step(4);
		`CHK("early ready", 1'h0, req_ready_o)
		$display("test reset done");
		foreach (rows[i]) xfer(rows[i]);
		$display("test rows done");
		// Request held while supply is out must be ignored
		supply_good_i = 1'h0;
		{req_valid_i, req_write_i} = 2'h3;
		step(3);
		`CHK("refused", 3'h6, {chip_on_n_o, store_strobe_n_o, req_ready_o})
		{supply_good_i, req_valid_i} = 2'h2;
		xfer(rows[2]);
		$display("test supply done");
		ask(rows[4]);
		step(1);
		supply_good_i = 1'h0;
		step(2);
		`CHK("abort", 1'h1, store_strobe_n_o)
		supply_good_i = 1'h1;
		xfer(rows[3]);
		$display("test abort done");
		results();
	end
endmodule : tb_top
bind bbs_host bbs_host_asserts #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) bbs_host_asserts_inst (.*);
